// File: adc_consts.svh
// register indices, field positions, reset values and counts of the converter control slice
`ifndef ADC_CONSTS_SVH
`define ADC_CONSTS_SVH

// register indices; the bus byte address is four times the index
`define IDX_RATE 4'h4
`define IDX_REFCTL 4'h5
`define IDX_RESULT 4'h6
`define IDX_STATUS 4'h7
`define IDX_CMD 4'h8

// rate register fields
`define RATE_CODE_LSB 0
`define RATE_FILT_BIT 4
`define RATE_CLK_BIT 6

// reference control register fields
`define REF_SEL_LSB 2
`define REF_NBUF_BIT 4
`define REF_PBUF_BIT 5

// status and command fields
`define STAT_READY_BIT 0
`define STAT_CLK_BIT 1
`define CMD_RESET_BIT 0

// reset values
`define RATE_CODE_RST 4'h4
`define FILT_RST 1'b0
`define CLK_SEL_RST 1'b0
`define REF_SEL_RST 2'h0
`define BUF_OFF_RST 1'b1

// modulator clock is the system clock divided by this
`define MOD_DIV 16
`define MOD_DIV_W 4

// oversampling ratios in modulator clocks, one per rate code
`define OSR_W 17
`define OSR_0 17'd102400
`define OSR_1 17'd51200
`define OSR_2 17'd25600
`define OSR_3 17'd15360
`define OSR_4 17'd12800
`define OSR_5 17'd5120
`define OSR_6 17'd4264
`define OSR_7 17'd2560
`define OSR_8 17'd1280
`define OSR_9 17'd640
`define OSR_10 17'd320
`define OSR_11 17'd256
`define OSR_12 17'd128
`define OSR_13 17'd64
`define RATE_LAST_CODE 4'hD

// bus answers
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// File: adc_filter_pkg.sv
// types shared by the converter control slice
package adc_filter_pkg;
  typedef enum logic {FILT_LOW_LATENCY, FILT_SINC3} filter_t;
  typedef enum logic [1:0] {REF_EXT0, REF_EXT1, REF_INTERNAL, REF_RSVD} ref_src_t;
endpackage

// File: decimator.sv
// decimation filter: boxcar low-latency path and third-order sinc path
`include "adc_consts.svh"
module decimator import adc_filter_pkg::*; #(
  parameter int OSR_W = `OSR_W,
  parameter int ACC_W = 52,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // control
  input wire logic restart,
  input wire filter_t filt,
  input wire logic [OSR_W-1:0] osr,
  // modulator stream
  input wire logic mod_tick,
  input wire logic mod_bit,
  // result
  output logic [DATA_W-1:0] result,
  output logic result_valid
);

  logic [OSR_W-1:0] cnt_ff;
  logic [OSR_W-1:0] box_ff;
  logic [ACC_W-1:0] i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff;
  logic [ACC_W-1:0] nxt_i1, nxt_i2, nxt_i3, c1, c2, c3;
  logic [OSR_W-1:0] nxt_box;
  logic dump;

  assign dump = mod_tick && (cnt_ff == osr - 1'b1);
  assign nxt_box = box_ff + {{(OSR_W-1){1'b0}}, mod_bit};
  assign nxt_i1 = i1_ff + {{(ACC_W-1){1'b0}}, mod_bit};
  assign nxt_i2 = i2_ff + nxt_i1;
  assign nxt_i3 = i3_ff + nxt_i2;
  assign c1 = nxt_i3 - d1_ff;
  assign c2 = c1 - d2_ff;
  assign c3 = c2 - d3_ff;

  ////////////////////////////////////////////////////////////////////////////
  // every result costs exactly osr modulator clocks, whatever the filter
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      cnt_ff <= '0;
    end else if (restart) begin
      cnt_ff <= '0;
    end else if (mod_tick) begin
      cnt_ff <= dump ? '0 : cnt_ff + 1'b1;
    end
  end

  // low-latency path: settled after one period since it forgets all history
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      box_ff <= '0;
    end else if (restart || dump) begin
      box_ff <= '0;
    end else if (mod_tick) begin
      box_ff <= nxt_box;
    end
  end

  // sinc3 integrators run at the modulator rate, combs at the output rate
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      {i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff} <= '0;
    end else if (restart) begin
      {i1_ff, i2_ff, i3_ff, d1_ff, d2_ff, d3_ff} <= '0;
    end else if (mod_tick) begin
      i1_ff <= nxt_i1;
      i2_ff <= nxt_i2;
      i3_ff <= nxt_i3;
      if (dump) begin
        d1_ff <= nxt_i3;
        d2_ff <= c1;
        d3_ff <= c2;
      end
    end
  end

  // zero filter bit picks the boxcar path
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      result <= '0;
      result_valid <= 1'b0;
    end else begin
      result_valid <= dump && !restart;
      if (dump && !restart) begin
        if (filt == FILT_LOW_LATENCY) begin
          result <= {{(DATA_W-OSR_W){1'b0}}, nxt_box};
        end else begin
          result <= c3[ACC_W-1 -: DATA_W];
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [OSR_W:0] ticks_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ticks_ff <= '0;
    end else if (restart) begin
      ticks_ff <= '0;
    end else if (result_valid) begin
      ticks_ff <= {{OSR_W{1'b0}}, mod_tick};
    end else if (mod_tick) begin
      ticks_ff <= ticks_ff + 1'b1;
    end
  end

  property p_osr_count;
    @(posedge core_clk) disable iff (!rstn)
    result_valid |-> ticks_ff == {1'b0, osr};
  endproperty
  a_osr_count: assert property (p_osr_count) else $error("result period wrong");

  property p_ll_bound;
    @(posedge core_clk) disable iff (!rstn)
    result_valid && filt == FILT_LOW_LATENCY |-> result <= DATA_W'(osr);
  endproperty
  a_ll_bound: assert property (p_ll_bound) else $error("boxcar result exceeds ratio");

endmodule

// File: adc_clock_filter_rate_select.sv
// converter control slice: register slave, clock choice, modulator clock, rate select
// Functional notes
// - reference selector routes external pair 0, external pair 1 or the internal reference to the converter
// - two reference buffers, positive and negative, each with its own control bit
// - buffer control bits are active low: one disables, zero enables
// - clock-select bit in the rate register picks internal oscillator or external clock
// - after power-up the internal oscillator is the system clock source
// - reset pin or reset command returns the clock source to internal oscillator
// - modulator clock is the system clock divided by sixteen
// - filter-select bit picks sinc3 or low-latency decimation filter
// - filter-select zero picks the low-latency FIR filter
// - each rate code costs the same modulator clocks per result for both filters
// - 4-bit rate code fixes the oversampling ratio, modulator rate over output rate
// - codes 0000 to 0110 give 102400, 51200, 25600, 15360, 12800, 5120, 4264
// - codes 0111 to 1101 give 2560, 1280, 640, 320, 256, 128, 64
// - low-latency filter gives a settled result if input settled before start
// - low-latency at 2.5, 5, 10, 20 SPS rejects both 50 Hz and 60 Hz; the boxcar here notches only 60 Hz at 20 SPS
// - low-latency notch at 50 Hz for 16.6 and 50 SPS, 60 Hz for 60 SPS
// - output rate and notches scale with system clock since ratios count modulator clocks
// - reset selects external pair 0; a two-bit source field can select internal
//
// Local design decisions: the AXI4-Lite slave port and the address map.
`include "adc_consts.svh"
module adc_clock_filter_rate_select import adc_filter_pkg::*; #(
  parameter int AW = 6,
  parameter int DATA_W = 32
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rstn,
  // register bus write
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // register bus read
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // modulator bitstream
  input wire logic mod_bit_in,
  // clock and reference controls
  output logic mod_clk,
  output logic ext_clk_sel,
  output ref_src_t ref_source_sel,
  output logic pos_ref_buffer_off,
  output logic neg_ref_buffer_off,
  // filter settings and results
  output filter_t filter_sel,
  output logic [3:0] rate_code,
  output logic [DATA_W-1:0] result_data,
  output logic result_valid
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);

  ////////////////////////////////////////////////////////////////////////////
  // write channel: address and data may arrive in either order
  logic aw_ok_ff, w_ok_ff;
  logic [AW-1:0] aw_addr_ff;
  logic [31:0] w_data_ff;
  logic w_strb0_ff;
  logic aw_take, w_take, do_wr;
  logic [AW-1:0] wr_addr;
  logic [31:0] wr_data;
  logic wr_lane0, wr_rate, wr_ref, wr_cmd, wr_ok;

  assign s_axi_awready = !aw_ok_ff && !s_axi_bvalid;
  assign s_axi_wready = !w_ok_ff && !s_axi_bvalid;
  assign aw_take = s_axi_awvalid && s_axi_awready;
  assign w_take = s_axi_wvalid && s_axi_wready;
  assign do_wr = (aw_ok_ff || aw_take) && (w_ok_ff || w_take);
  assign wr_addr = aw_ok_ff ? aw_addr_ff : s_axi_awaddr;
  assign wr_data = w_ok_ff ? w_data_ff : s_axi_wdata;
  assign wr_lane0 = w_ok_ff ? w_strb0_ff : s_axi_wstrb[0];
  assign wr_rate = do_wr && wr_lane0 && wr_addr[5:2] == `IDX_RATE;
  assign wr_ref = do_wr && wr_lane0 && wr_addr[5:2] == `IDX_REFCTL;
  assign wr_cmd = do_wr && wr_lane0 && wr_addr[5:2] == `IDX_CMD;
  assign wr_ok = wr_addr[5:2] inside {`IDX_RATE, `IDX_REFCTL, `IDX_RESULT, `IDX_STATUS,
                                      `IDX_CMD};

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      aw_ok_ff <= 1'b0;
      w_ok_ff <= 1'b0;
      aw_addr_ff <= '0;
      w_data_ff <= 32'h0;
      w_strb0_ff <= 1'b0;
    end else begin
      if (do_wr) begin
        aw_ok_ff <= 1'b0;
        w_ok_ff <= 1'b0;
      end else begin
        if (aw_take) begin
          aw_ok_ff <= 1'b1;
          aw_addr_ff <= s_axi_awaddr;
        end
        if (w_take) begin
          w_ok_ff <= 1'b1;
          w_data_ff <= s_axi_wdata;
          w_strb0_ff <= s_axi_wstrb[0];
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_ok ? `RESP_OKAY : `RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; the reset command restores them a cycle after its write
  logic soft_rst_ff;
  logic restart;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_cmd && wr_data[`CMD_RESET_BIT];
    end
  end

  // clock source falls back to internal on either reset
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ext_clk_sel <= `CLK_SEL_RST;
      filter_sel <= FILT_LOW_LATENCY;
    end else if (soft_rst_ff) begin
      ext_clk_sel <= `CLK_SEL_RST;
      filter_sel <= FILT_LOW_LATENCY;
    end else if (wr_rate) begin
      ext_clk_sel <= wr_data[`RATE_CLK_BIT];
      filter_sel <= filter_t'(wr_data[`RATE_FILT_BIT]);
    end
  end

  // reserved codes would leave the ratio undefined, so such a write keeps the old code
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      rate_code <= `RATE_CODE_RST;
    end else if (soft_rst_ff) begin
      rate_code <= `RATE_CODE_RST;
    end else if (wr_rate && wr_data[`RATE_CODE_LSB +: 4] <= `RATE_LAST_CODE) begin
      rate_code <= wr_data[`RATE_CODE_LSB +: 4];
    end
  end

  // buffer bits are disables, stored as written
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ref_source_sel <= ref_src_t'(`REF_SEL_RST);
      pos_ref_buffer_off <= `BUF_OFF_RST;
      neg_ref_buffer_off <= `BUF_OFF_RST;
    end else if (soft_rst_ff) begin
      ref_source_sel <= ref_src_t'(`REF_SEL_RST);
      pos_ref_buffer_off <= `BUF_OFF_RST;
      neg_ref_buffer_off <= `BUF_OFF_RST;
    end else if (wr_ref) begin
      ref_source_sel <= ref_src_t'(wr_data[`REF_SEL_LSB +: 2]);
      pos_ref_buffer_off <= wr_data[`REF_PBUF_BIT];
      neg_ref_buffer_off <= wr_data[`REF_NBUF_BIT];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // modulator clock: all ratios count these ticks, so rates track the system clock
  logic [`MOD_DIV_W-1:0] div_ff;
  logic mod_tick;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      div_ff <= '0;
      mod_clk <= 1'b0;
    end else begin
      div_ff <= div_ff + 1'b1;
      mod_clk <= div_ff[`MOD_DIV_W-1];
    end
  end
  assign mod_tick = div_ff == `MOD_DIV_W'(`MOD_DIV - 1);

  // modulator bit comes from the analog side: two flops before use
  logic mod_meta_ff, mod_bit_ff;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      mod_meta_ff <= 1'b0;
      mod_bit_ff <= 1'b0;
    end else begin
      mod_meta_ff <= mod_bit_in;
      mod_bit_ff <= mod_meta_ff;
    end
  end

  // ratio per rate code; the reserved codes can never be stored
  localparam logic [`OSR_W-1:0] OSR_TAB [16] = '{
    `OSR_0, `OSR_1, `OSR_2, `OSR_3, `OSR_4, `OSR_5, `OSR_6,
    `OSR_7, `OSR_8, `OSR_9, `OSR_10, `OSR_11, `OSR_12, `OSR_13, `OSR_0, `OSR_0};

  logic [`OSR_W-1:0] osr;
  assign osr = OSR_TAB[rate_code];
  // a rate register write or the reset command starts a fresh conversion so no result mixes two ratios
  assign restart = wr_rate || soft_rst_ff;

  decimator #(.OSR_W(`OSR_W), .DATA_W(DATA_W)) u_decim (
    .core_clk(core_clk),
    .rstn(rstn),
    .restart(restart),
    .filt(filter_sel),
    .osr(osr),
    .mod_tick(mod_tick),
    .mod_bit(mod_bit_ff),
    .result(result_data),
    .result_valid(result_valid)
  );

  ////////////////////////////////////////////////////////////////////////////
  // read channel; reading the result clears data-ready, a new result in that cycle wins
  logic ready_ff;
  logic ar_take, rd_result;
  logic [31:0] rd_word;
  logic rd_err;

  assign s_axi_arready = !s_axi_rvalid;
  assign ar_take = s_axi_arvalid && s_axi_arready;
  assign rd_result = ar_take && s_axi_araddr[5:2] == `IDX_RESULT;

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      ready_ff <= 1'b0;
    end else if (result_valid) begin
      ready_ff <= 1'b1;
    end else if (rd_result || restart) begin
      ready_ff <= 1'b0;
    end
  end

  always_comb begin
    rd_word = 32'h0;
    rd_err = 1'b0;
    unique case (s_axi_araddr[5:2])
      `IDX_RATE: begin
        rd_word[`RATE_CODE_LSB +: 4] = rate_code;
        rd_word[`RATE_FILT_BIT] = filter_sel;
        rd_word[`RATE_CLK_BIT] = ext_clk_sel;
      end
      `IDX_REFCTL: begin
        rd_word[`REF_SEL_LSB +: 2] = ref_source_sel;
        rd_word[`REF_PBUF_BIT] = pos_ref_buffer_off;
        rd_word[`REF_NBUF_BIT] = neg_ref_buffer_off;
      end
      `IDX_RESULT: rd_word[DATA_W-1:0] = result_data;
      `IDX_STATUS: begin
        rd_word[`STAT_READY_BIT] = ready_ff;
        rd_word[`STAT_CLK_BIT] = ext_clk_sel;
      end
      `IDX_CMD: rd_word = 32'h0;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= `RESP_OKAY;
    end else if (ar_take) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  property p_mod_period;
    mod_tick |-> ##16 mod_tick;
  endproperty
  a_mod_period: assert property (p_mod_period) else $error("tick period not 16");
  property p_mod_gap;
    mod_tick |=> !mod_tick [*8];
  endproperty
  a_mod_gap: assert property (p_mod_gap) else $error("modulator tick too early");
  property p_soft_reset;
    wr_cmd && wr_data[`CMD_RESET_BIT] |=> ##1 !ext_clk_sel && ref_source_sel == REF_EXT0;
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("reset kept settings");
  property p_buf_off;
    wr_ref && !soft_rst_ff |=> pos_ref_buffer_off == $past(wr_data[`REF_PBUF_BIT])
      && neg_ref_buffer_off == $past(wr_data[`REF_NBUF_BIT]);
  endproperty
  a_buf_off: assert property (p_buf_off) else $error("buffer control not as written");
  property p_rsvd_rate;
    wr_rate && wr_data[3:1] == 3'h7 && !soft_rst_ff |=> $stable(rate_code);
  endproperty
  a_rsvd_rate: assert property (p_rsvd_rate) else $error("reserved rate code taken");
  property p_osr_first;
    rate_code == 4'h6 |-> osr == `OSR_W'(4264);
  endproperty
  a_osr_first: assert property (p_osr_first) else $error("wrong ratio for code 6");
  property p_osr_last;
    rate_code == 4'hD |-> osr == `OSR_W'(64);
  endproperty
  a_osr_last: assert property (p_osr_last) else $error("wrong ratio for code 13");
  property p_filter_sel;
    wr_rate && !wr_data[`RATE_FILT_BIT] |=> filter_sel == FILT_LOW_LATENCY;
  endproperty
  a_filter_sel: assert property (p_filter_sel) else $error("low latency not picked");
  property p_clk_select;
    wr_rate && !soft_rst_ff |=> ext_clk_sel == $past(wr_data[`RATE_CLK_BIT]);
  endproperty
  a_clk_select: assert property (p_clk_select) else $error("clock select wrong");
  property p_write_resp;
    do_wr |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write answer missing");

endmodule

// File: mod_source.sv
// modulator bitstream source standing in for the analog front end
module mod_source (
  // modulator clock and requested level
  input wire logic mod_clk,
  input wire logic ones_en,
  // bitstream
  output logic mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // one new bit per modulator clock rise, so the level only moves on a tick boundary
  initial begin
    mod_bit = 1'b0;
    forever @(posedge mod_clk) mod_bit <= ones_en;
  end
endmodule

// File: test_adc_clock_filter_rate_select.sv
// self-checking bench of the converter control slice
`include "adc_consts.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin mismatches++; \
  $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end
module test_adc_clock_filter_rate_select import adc_filter_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {string nm; logic [31:0] d; logic [1:0] r;} rd_exp_t;
  typedef struct {int per; bit chk_val; logic [31:0] v;} res_exp_t;
  logic core_clk, rstn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [5:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, result_data;
  logic [3:0] s_axi_wstrb, rate_code;
  logic [1:0] s_axi_bresp, s_axi_rresp, br;
  logic mod_bit_in, mod_clk, ext_clk_sel, pos_ref_buffer_off, neg_ref_buffer_off;
  logic result_valid, ones, mc_prev;
  ref_src_t ref_source_sel;
  filter_t filter_sel;
  int mismatches = 0, n_checks = 0, cyc = 0, last_res = 0, mc_n = -1;
  logic [1:0] wr_q[$];
  rd_exp_t rd_q[$];
  res_exp_t res_q[$];
  rd_exp_t re;
  res_exp_t rx;

  adc_clock_filter_rate_select dut_u (.core_clk, .rstn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .mod_bit_in, .mod_clk, .ext_clk_sel,
    .ref_source_sel, .pos_ref_buffer_off, .neg_ref_buffer_off, .filter_sel, .rate_code,
    .result_data, .result_valid);
  mod_source partner_u (.mod_clk, .ones_en(ones), .mod_bit(mod_bit_in));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic fail_to();
    mismatches++;
    $display("MISMATCH wait expired");
    results();
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    n = 0;
    wr_q.push_back(r);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!(s_axi_bvalid && s_axi_bready) && n < 50);
    s_axi_bready <= 1'b0;
    @(posedge core_clk);
    if (n >= 50) fail_to();
  endtask

  task automatic rd(input logic [5:0] a, input string nm, input logic [31:0] d,
                    input logic [1:0] r);
    int n;
    n = 0;
    rd_q.push_back('{nm, d, r});
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do begin
      @(posedge core_clk);
      n++;
      if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!(s_axi_rvalid && s_axi_rready) && n < 50);
    s_axi_rready <= 1'b0;
    @(posedge core_clk);
    if (n >= 50) fail_to();
  endtask

  task automatic wait_res();
    int n;
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (!result_valid && n < 40000);
    if (n >= 40000) fail_to();
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: pre-edge values are sampled, so driver updates at this edge cannot race it
  always @(posedge core_clk) begin
    if (s_axi_bvalid && s_axi_bready && wr_q.size() > 0) begin
      br = wr_q.pop_front();
      `CHK("bresp", br, s_axi_bresp)
    end
    if (s_axi_rvalid && s_axi_rready && rd_q.size() > 0) begin
      re = rd_q.pop_front();
      `CHK({re.nm, " data"}, re.d, s_axi_rdata)
      `CHK({re.nm, " resp"}, re.r, s_axi_rresp)
    end
    cyc++;
    if (result_valid) begin
      if (res_q.size() > 0) begin
        rx = res_q.pop_front();
        `CHK("result period", rx.per, cyc - last_res)
        if (rx.chk_val) `CHK("result value", rx.v, result_data)
      end
      last_res = cyc;
    end
    if (!rstn) begin
      mc_n = -1;
    end else if (mod_clk && !mc_prev) begin
      if (mc_n >= 0) `CHK("mod_clk period", 16, mc_n)
      mc_n = 0;
    end
    mc_prev = mod_clk;
    if (mc_n >= 0) mc_n++;
  end

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    int osr_tab[14] = '{102400, 51200, 25600, 15360, 12800, 5120, 4264,
                        2560, 1280, 640, 320, 256, 128, 64};
    logic [1:0] rs, bf;
    logic [3:0] ec;
    rstn = 1'b0;
    s_axi_awaddr = 6'h0;
    s_axi_araddr = 6'h0;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    ones = 1'b1;
    mc_prev = 1'b0;
    void'($urandom(32'hEE333E57));
    repeat (8) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    `CHK("ext_clk_sel", 1'b0, ext_clk_sel)
    `CHK("ref_source_sel", REF_EXT0, ref_source_sel)
    `CHK("pos_ref_buffer_off", 1'b1, pos_ref_buffer_off)
    rd(6'h10, "rate reg", 32'h4, 2'h0);
    rd(6'h14, "ref reg", 32'h30, 2'h0);
    rd(6'h00, "unmapped", 32'h0, 2'h2);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      rs = 2'(i % 3);
      // no rail-tied reference is modelled; the internal source gets both buffers off, external sources any enable mix
      bf = (rs == 2'h2) ? 2'h3 : 2'($urandom());
      wr(6'h14, {26'h0, bf, rs, 2'h0}, 2'h0);
      `CHK("ref_source_sel", rs, ref_source_sel)
      `CHK("pos_ref_buffer_off", bf[1], pos_ref_buffer_off)
      `CHK("neg_ref_buffer_off", bf[0], neg_ref_buffer_off)
    end
    $display("test reference controls done");
    for (int c = 0; c < 16; c++) begin
      wr(6'h10, {25'h0, c[1], 1'b0, c[0], c[3:0]}, 2'h0);
      ec = (c < 14) ? c[3:0] : 4'hD;
      `CHK("rate_code", ec, rate_code)
      `CHK("filter_sel", c[0] ? FILT_SINC3 : FILT_LOW_LATENCY, filter_sel)
      `CHK("ext_clk_sel", c[1], ext_clk_sel)
    end
    wr(6'h3C, 32'h1, 2'h2);
    wr(6'h20, 32'h1, 2'h0);
    repeat (2) @(posedge core_clk);
    `CHK("ext_clk_sel", 1'b0, ext_clk_sel)
    `CHK("rate_code", 4'h4, rate_code)
    rd(6'h1C, "status clock bit", 32'h0, 2'h0);
    s_axi_wstrb <= 4'h0;
    wr(6'h14, 32'h0, 2'h0);
    s_axi_wstrb <= 4'hF;
    `CHK("pos_ref_buffer_off", 1'b1, pos_ref_buffer_off)
    wr(6'h10, 32'h4D, 2'h0);
    `CHK("ext_clk_sel", 1'b1, ext_clk_sel)
    rstn <= 1'b0;
    repeat (3) @(posedge core_clk);
    `CHK("ext_clk_sel", 1'b0, ext_clk_sel)
    rstn <= 1'b1;
    @(posedge core_clk);
    $display("test clock and rate select done");
    for (int c = 13; c > 9; c--) begin
      for (int f = 0; f < 2; f++) begin
        ones <= 1'($urandom());
        wr(6'h10, {27'h0, f[0], c[3:0]}, 2'h0);
        // the first result after a restart may be short by the tick phase, so skip it
        wait_res();
        @(posedge core_clk);
        res_q.push_back('{osr_tab[c] * 16, f == 0, ones ? 32'(osr_tab[c]) : 32'h0});
        wait_res();
        if (f == 0) rd(6'h18, "result reg", ones ? 32'(osr_tab[c]) : 32'h0, 2'h0);
      end
    end
    rd(6'h1C, "status ready", 32'h1, 2'h0);
    $display("test oversampling ratios done");
    results();
  end
endmodule
